// ==== nesbb_cfg.svh ====
// offsets, field positions, command codes and timing counts of the host
`ifndef NESBB_CFG_SVH
`define NESBB_CFG_SVH
// -----------------------------------------------------------------
// register offsets of the host command port
// -----------------------------------------------------------------
`define NESBB_OFF_CTRL 8'h00
`define NESBB_OFF_CMD 8'h04
`define NESBB_OFF_ROW 8'h08
`define NESBB_OFF_COL 8'h0c
`define NESBB_OFF_STAT 8'h10
// control bits
`define NESBB_CTRL_WP 0
`define NESBB_CTRL_SCAN 1
`define NESBB_CTRL_CLR 2
// -----------------------------------------------------------------
// flash command bytes and status byte bits
// -----------------------------------------------------------------
`define NESBB_FC_STATUS 8'h70
`define NESBB_FC_READ 8'h00
`define NESBB_FC_READ2 8'h30
`define NESBB_FC_ERASE 8'h60
`define NESBB_FC_ERASE2 8'hd0
`define NESBB_SB_FAIL 0
`define NESBB_SB_EDC_ERR 1
`define NESBB_SB_EDC_VALID 2
`define NESBB_SB_READY 6
`define NESBB_ERASED 8'hff
// -----------------------------------------------------------------
// page geometry
// -----------------------------------------------------------------
`define NESBB_PAGE_BYTES 12'h840
`define NESBB_MARK_COL 12'h800
`define NESBB_MAIN_WORDS 12'h400
`define NESBB_PAGE_WORDS 12'h420
// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define NESBB_CLK_MHZ 10
`define NESBB_TWW_NS 100
`define NESBB_TWW_CYC ((`NESBB_TWW_NS * `NESBB_CLK_MHZ + 999) / 1000)
`define NESBB_TWB_CYC 4'h2
`endif

// ==== nesbb_pkg.sv ====
// types shared by the flash host controller
package nesbb_pkg;
  // pin group driven toward the flash
  typedef struct packed {
    logic cle;
    logic ale;
    logic ce_n;
    logic we_n;
    logic re_n;
    logic oe;
    logic [7:0] io;
  } nesbb_pins_t;
  // operations software may start
  typedef enum logic [1:0] {
    OP_STATUS = 2'h0,
    OP_MARK = 2'h1,
    OP_ERASE = 2'h2
  } nesbb_op_t;
  // sequencer states, gray along cmd-addr-cmd2-wait-read
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CMD = 3'h1,
    ST_ADDR = 3'h3,
    ST_CMD2 = 3'h2,
    ST_WAIT = 3'h6,
    ST_READ = 3'h7
  } nesbb_state_t;
endpackage

// ==== nesbb_host.sv ====
// host controller: status decode, marker check and guarded erase
//
// Chosen here: the address-and-strobe port and the address map.
`include "nesbb_cfg.svh"

// Function
// R1: decode fail, detect-error and validity status bits
// R2: decode ready and write-protect status bits; ready only gates detect-error, write-protect is not decoded
// R3: word page has four 264-word sectors
// R4: main sectors to 1023, spare to 1055
// R5: chip select released while flash busy
// R6: no reliance on cross-page sequential read
// R7: byte page load is 2112 cycles
// R8: erased locations read all ones
// R9: marker byte not FFh means bad block
// R10: marker column 2048 checked on chosen pages
// R11: block zero is always valid
// R12: markers read before any erase allowed
// R13: grown bad block reports status failure
// R14: failed program leaves other pages intact
// R15: program or erase failure asks replacement
// R16: replacement flag held until software clears
// R17: write protect blocks program and erase
// R18: detect-error used only when valid and ready
module nesbb_host
(
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic NAND_CLE,
  output logic NAND_ALE,
  output logic NAND_CE_N,
  output logic NAND_WE_N,
  output logic NAND_RE_N,
  output logic NAND_WP_N,
  output logic NAND_IO_OE,
  output logic [7:0] NAND_IO_OUT,
  input wire logic [7:0] NAND_IO_IN,
  input wire logic NAND_RB
);
  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  nesbb_pkg::nesbb_state_t st_reg, st_next; // sequencer state
  nesbb_pkg::nesbb_op_t op_reg, op_next; // running operation
  nesbb_pkg::nesbb_pins_t pins_reg, pins_next; // flash pins
  logic ph_reg, ph_next; // strobe phase, 1 = strobe high
  logic post_reg, post_next; // erase done, status read pending
  logic [7:0] cmd_reg, cmd_next; // command byte in flight
  logic [2:0] idx_reg, idx_next; // address cycle index
  logic [3:0] wait_reg, wait_next; // busy settle count
  logic [23:0] row_reg, row_next; // row address
  logic [11:0] col_reg, col_next; // column address
  logic wp_reg, wp_next; // 1 = writes allowed
  logic [3:0] tww_reg, tww_next; // protect settle count
  logic scan_reg, scan_next; // marker scan finished
  logic [7:0] res_reg, res_next; // last byte read
  logic bad_reg, bad_next; // marker said bad
  logic fail_reg, fail_next; // status fail bit
  logic edc_err_reg, edc_err_next; // trusted detect-error
  logic edc_val_reg, edc_val_next; // detect result valid
  logic repl_reg, repl_next; // block replacement wanted
  logic refused_reg, refused_next; // start refused
  logic [31:0] rdata_reg, rdata_next; // read answer
  // helpers
  logic [7:0] addr_byte; // address byte for idx_reg
  logic [1:0] sector; // word-wide sector of col_reg
  logic spare_sel; // col_reg lies in spare area
  logic col_err; // col_reg beyond the page
  logic wp_ready; // writes enabled and settled
  logic start; // start strobe
  logic refuse; // start must be refused
  logic clr; // sticky flag clear
  nesbb_pkg::nesbb_op_t req_op; // requested operation

  // -----------------------------------------------------------------
  // decode helpers
  // -----------------------------------------------------------------
  // sector of a word column; spare sector index from bits 4:3
  always_comb
  begin
    spare_sel = col_reg >= `NESBB_MAIN_WORDS; // R4
    sector = spare_sel ? col_reg[4:3] : col_reg[9:8]; // R3
    col_err = col_reg >= `NESBB_PAGE_BYTES; // R7
    wp_ready = wp_reg && (tww_reg == 4'h0); // R17
    req_op = nesbb_pkg::nesbb_op_t'(WDATA[1:0]);
    start = WR && (ADDR == `NESBB_OFF_CMD);
    clr = WR && (ADDR == `NESBB_OFF_CTRL) && WDATA[`NESBB_CTRL_CLR];
    // erase waits for the scan since erase may wipe the markers
    refuse = (st_reg != nesbb_pkg::ST_IDLE)
      || (req_op == nesbb_pkg::OP_ERASE && (!scan_reg || !wp_ready)) // R12
      || (req_op == nesbb_pkg::OP_MARK && col_err) // R7
      || (req_op != nesbb_pkg::OP_STATUS && req_op != nesbb_pkg::OP_MARK
          && req_op != nesbb_pkg::OP_ERASE);
    // column low, column high, then three row bytes
    if (idx_reg == 3'h0)
      addr_byte = col_reg[7:0];
    else if (idx_reg == 3'h1)
      addr_byte = {4'h0, col_reg[11:8]};
    else if (idx_reg == 3'h2)
      addr_byte = row_reg[7:0];
    else if (idx_reg == 3'h3)
      addr_byte = row_reg[15:8];
    else
      addr_byte = row_reg[23:16];
  end

  // -----------------------------------------------------------------
  // next values: registers, sequencer, pins
  // -----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    op_next = op_reg;
    ph_next = ph_reg;
    post_next = post_reg;
    cmd_next = cmd_reg;
    idx_next = idx_reg;
    wait_next = wait_reg;
    row_next = row_reg;
    col_next = col_reg;
    wp_next = wp_reg;
    scan_next = scan_reg;
    res_next = res_reg;
    bad_next = bad_reg;
    fail_next = fail_reg;
    edc_err_next = edc_err_reg;
    edc_val_next = edc_val_reg;
    repl_next = repl_reg && !clr; // set below wins over clear  R16
    refused_next = refused_reg && !clr;
    tww_next = (tww_reg != 4'h0) ? tww_reg - 4'h1 : 4'h0;
    pins_next = pins_reg;
    pins_next.we_n = 1'b1;
    pins_next.re_n = 1'b1;
    rdata_next = 32'h0;
    // software writes
    if (WR && ADDR == `NESBB_OFF_CTRL)
    begin
      wp_next = WDATA[`NESBB_CTRL_WP];
      scan_next = WDATA[`NESBB_CTRL_SCAN];
      if (WDATA[`NESBB_CTRL_WP] != wp_reg)
        tww_next = 4'(`NESBB_TWW_CYC); // R17
    end
    else if (WR && ADDR == `NESBB_OFF_ROW)
      row_next = WDATA[23:0];
    else if (WR && ADDR == `NESBB_OFF_COL)
      col_next = WDATA[11:0];
    // software reads, answered next cycle
    if (RD && ADDR == `NESBB_OFF_CTRL)
      rdata_next = {29'h0, 1'b0, scan_reg, wp_reg};
    else if (RD && ADDR == `NESBB_OFF_ROW)
      rdata_next = {8'h0, row_reg};
    else if (RD && ADDR == `NESBB_OFF_COL)
      rdata_next = {20'h0, col_reg};
    else if (RD && ADDR == `NESBB_OFF_STAT)
      rdata_next = {12'h0, wp_ready, spare_sel, sector, col_err,
        refused_reg, repl_reg, edc_val_reg, edc_err_reg, fail_reg,
        bad_reg, (st_reg != nesbb_pkg::ST_IDLE), res_reg};
    // refused starts are noted in any state, busy ones included
    if (start && refuse)
      refused_next = 1'b1;
    // sequencer
    case (st_reg)
      nesbb_pkg::ST_IDLE:
      begin
        pins_next = '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1,
          re_n: 1'b1, oe: 1'b0, io: 8'h00};
        ph_next = 1'b0;
        if (start && !refuse)
        begin
          st_next = nesbb_pkg::ST_CMD;
          op_next = req_op;
          post_next = 1'b0;
          idx_next = (req_op == nesbb_pkg::OP_ERASE) ? 3'h2 : 3'h0;
          if (req_op == nesbb_pkg::OP_STATUS)
            cmd_next = `NESBB_FC_STATUS;
          else if (req_op == nesbb_pkg::OP_MARK)
            cmd_next = `NESBB_FC_READ;
          else
            cmd_next = `NESBB_FC_ERASE;
        end
      end
      nesbb_pkg::ST_CMD, nesbb_pkg::ST_CMD2, nesbb_pkg::ST_ADDR:
      begin
        pins_next.ce_n = 1'b0;
        pins_next.oe = 1'b1;
        pins_next.cle = (st_reg != nesbb_pkg::ST_ADDR);
        pins_next.ale = (st_reg == nesbb_pkg::ST_ADDR);
        if (st_reg == nesbb_pkg::ST_ADDR)
          pins_next.io = addr_byte;
        else if (st_reg == nesbb_pkg::ST_CMD2)
          pins_next.io = (op_reg == nesbb_pkg::OP_MARK)
            ? `NESBB_FC_READ2 : `NESBB_FC_ERASE2;
        else
          pins_next.io = cmd_reg;
        pins_next.we_n = ph_reg; // low phase then high phase
        ph_next = !ph_reg;
        if (ph_reg)
        begin
          if (st_reg == nesbb_pkg::ST_CMD2)
          begin
            st_next = nesbb_pkg::ST_WAIT;
            wait_next = `NESBB_TWB_CYC;
          end
          else if (st_reg == nesbb_pkg::ST_ADDR)
          begin
            idx_next = idx_reg + 3'h1;
            if (idx_reg == 3'h4)
              st_next = nesbb_pkg::ST_CMD2;
          end
          else if (op_reg == nesbb_pkg::OP_STATUS || post_reg)
            st_next = nesbb_pkg::ST_READ;
          else
            st_next = nesbb_pkg::ST_ADDR;
        end
      end
      nesbb_pkg::ST_WAIT:
      begin
        // chip select let go while the flash works
        pins_next.ce_n = 1'b1; // R5
        pins_next.cle = 1'b0;
        pins_next.ale = 1'b0;
        pins_next.oe = 1'b0;
        ph_next = 1'b0;
        if (wait_reg != 4'h0)
          wait_next = wait_reg - 4'h1;
        else if (NAND_RB && op_reg == nesbb_pkg::OP_ERASE)
        begin
          // erase result only shows in the status byte
          st_next = nesbb_pkg::ST_CMD;
          cmd_next = `NESBB_FC_STATUS;
          post_next = 1'b1;
        end
        else if (NAND_RB)
          st_next = nesbb_pkg::ST_READ; // R6
      end
      nesbb_pkg::ST_READ:
      begin
        pins_next.ce_n = 1'b0;
        pins_next.cle = 1'b0;
        pins_next.ale = 1'b0;
        pins_next.oe = 1'b0;
        pins_next.re_n = ph_reg;
        ph_next = !ph_reg;
        if (ph_reg)
        begin
          // one byte only: never walk into the next page
          st_next = nesbb_pkg::ST_IDLE;
          res_next = NAND_IO_IN;
          if (op_reg == nesbb_pkg::OP_MARK)
          begin
            bad_next = NAND_IO_IN != `NESBB_ERASED; // R9
            // marker replaces the status byte, so its detect-error verdict goes; fail and valid bits stay
            edc_err_next = 1'b0; // R18
          end
          else
          begin
            fail_next = NAND_IO_IN[`NESBB_SB_FAIL]; // R1
            edc_val_next = NAND_IO_IN[`NESBB_SB_EDC_VALID]; // R1
            edc_err_next = NAND_IO_IN[`NESBB_SB_EDC_ERR]
              && NAND_IO_IN[`NESBB_SB_EDC_VALID]
              && NAND_IO_IN[`NESBB_SB_READY]; // R18
            if (op_reg == nesbb_pkg::OP_ERASE && NAND_IO_IN[`NESBB_SB_FAIL])
              repl_next = 1'b1; // R15
          end
        end
      end
      default:
        st_next = nesbb_pkg::ST_IDLE;
    endcase
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      st_reg <= nesbb_pkg::ST_IDLE;
      op_reg <= nesbb_pkg::OP_STATUS;
      pins_reg <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1,
        re_n: 1'b1, oe: 1'b0, io: 8'h00};
      ph_reg <= 1'b0;
      post_reg <= 1'b0;
      cmd_reg <= 8'h00;
      idx_reg <= 3'h0;
      wait_reg <= 4'h0;
      row_reg <= 24'h0;
      col_reg <= `NESBB_MARK_COL; // R10
      wp_reg <= 1'b0; // protected until software says
      tww_reg <= 4'h0;
      scan_reg <= 1'b0;
      res_reg <= 8'h00;
      bad_reg <= 1'b0;
      fail_reg <= 1'b0;
      edc_err_reg <= 1'b0;
      edc_val_reg <= 1'b0;
      repl_reg <= 1'b0;
      refused_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end
    else
    begin
      st_reg <= st_next;
      op_reg <= op_next;
      pins_reg <= pins_next;
      ph_reg <= ph_next;
      post_reg <= post_next;
      cmd_reg <= cmd_next;
      idx_reg <= idx_next;
      wait_reg <= wait_next;
      row_reg <= row_next;
      col_reg <= col_next;
      wp_reg <= wp_next;
      tww_reg <= tww_next;
      scan_reg <= scan_next;
      res_reg <= res_next;
      bad_reg <= bad_next;
      fail_reg <= fail_next;
      edc_err_reg <= edc_err_next;
      edc_val_reg <= edc_val_next;
      repl_reg <= repl_next;
      refused_reg <= refused_next;
      rdata_reg <= rdata_next;
    end
  end

  // outputs straight from flip-flops
  assign RDATA = rdata_reg;
  assign NAND_CLE = pins_reg.cle;
  assign NAND_ALE = pins_reg.ale;
  assign NAND_CE_N = pins_reg.ce_n;
  assign NAND_WE_N = pins_reg.we_n;
  assign NAND_RE_N = pins_reg.re_n;
  assign NAND_WP_N = wp_reg;
  assign NAND_IO_OE = pins_reg.oe;
  assign NAND_IO_OUT = pins_reg.io;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  sequence s_mark_cap;
    st_reg == nesbb_pkg::ST_READ && ph_reg && op_reg == nesbb_pkg::OP_MARK;
  endsequence
  sequence s_erase_cap;
    st_reg == nesbb_pkg::ST_READ && ph_reg && op_reg == nesbb_pkg::OP_ERASE;
  endsequence
  AST_BAD_MARK: assert property (s_mark_cap |=> // R9
    bad_reg == ($past(NAND_IO_IN) != 8'hff))
    else $error("marker verdict wrong");
  AST_EDC_GATE: assert property (edc_err_reg |-> // R18
    edc_val_reg && res_reg[6])
    else $error("detect error trusted while invalid");
  AST_STATUS_FAIL: assert property (s_erase_cap |=> // R1
    fail_reg == $past(NAND_IO_IN[0]))
    else $error("fail bit not decoded");
  AST_ERASE_SCAN: assert property ((st_reg == nesbb_pkg::ST_IDLE // R12
    && st_next == nesbb_pkg::ST_CMD && op_next == nesbb_pkg::OP_ERASE)
    |-> scan_reg && wp_ready)
    else $error("erase started before scan");
  AST_REPLACE: assert property ((s_erase_cap ##0 NAND_IO_IN[0]) // R15
    |=> repl_reg [*2])
    else $error("replacement not flagged");
  AST_REPL_HOLD: assert property ((repl_reg && !clr) |=> repl_reg) // R16
    else $error("replacement flag lost");
  AST_CE_FREE: assert property ((st_reg == nesbb_pkg::ST_WAIT // R5
    && $past(st_reg) == nesbb_pkg::ST_WAIT) |-> NAND_CE_N)
    else $error("chip select held while busy");
  AST_MARK_COL: assert property ((start && !refuse // R7
    && req_op == nesbb_pkg::OP_MARK) |-> col_reg < 12'h840)
    else $error("column outside page");
  AST_SECTOR: assert property ((WR && ADDR == 8'h0c // R4
    && WDATA[11:0] >= 12'h400 && WDATA[11:0] < 12'h420)
    |=> spare_sel && sector == $past(WDATA[4:3]))
    else $error("spare sector misdecoded");
  AST_BYTE_SEQ: assert property ((st_reg == nesbb_pkg::ST_CMD2 // R5
    && ph_reg) |=> st_reg == nesbb_pkg::ST_WAIT ##[1:3] NAND_CE_N)
    else $error("no wait after second command");
endmodule // nesbb_host

// ==== nesbb_flash_model.sv ====
// behavioural flash device facing the host controller
module nesbb_flash_model
(
  input wire logic cle,
  input wire logic ale,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  input wire logic [7:0] bus,
  output logic [7:0] dout,
  output logic rb
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // device state
  // ----------------------------------------
  logic [7:0] cmd = 8'h00; // last command byte
  logic [7:0] adr [5]; // address bytes in arrival order
  int nadr = 0;
  logic [7:0] val = 8'h00; // byte last put out
  logic drive = 1'b0;
  logic fail = 1'b0; // status bits, bench may preset
  logic edc_err = 1'b0;
  logic edc_valid = 1'b0;
  logic wiped = 1'b0; // factory mark erased
  int busy_ns = 300; // bench picks prompt or slow
  int erases = 0;
  int bad_blk = 5; // never 0: block zero stays valid
  int worn_blk = 7;
  initial rb = 1'b1;
  // released bus shows the inverse, not a stale byte
  assign dout = drive ? val : ~val;
  // ----------------------------------------
  // busy and erase
  // ----------------------------------------
  // runs on with chip select released
  task automatic hold_busy();
    rb = 1'b0;
    // ready returns between host clock edges, never on one
    #(busy_ns + 30) rb = 1'b1;
  endtask
  task automatic erase_blk();
    int blk;
    blk = int'({adr[2], adr[1], adr[0]} >> 6);
    erases++;
    fail = (blk == worn_blk); // worn block fails
    // a failed erase leaves the stored bytes alone
    if (blk == bad_blk && !fail)
      wiped = 1'b1; // erase destroys the mark
    hold_busy();
  endtask
  // marker byte of the addressed page
  function automatic logic [7:0] mark_byte();
    logic [23:0] r;
    r = {adr[4], adr[3], adr[2]};
    if ({adr[1], adr[0]} == 16'h0800 && int'(r >> 6) == bad_blk
        && r[5:0] == 6'h00 && !wiped)
      return 8'h00;
    return 8'hff; // shipped cells read all ones
  endfunction
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  // bytes latch on the rising write strobe
  always @(posedge we_n)
    if (!ce_n && cle)
    begin
      cmd = bus;
      nadr = 0;
      if (bus == 8'h30)
        hold_busy();
      if (bus == 8'hd0 && wp_n) // protected erase never runs
        erase_blk();
    end
    else if (!ce_n && ale && nadr < 5)
    begin
      adr[nadr] = bus;
      nadr++;
    end
  // one byte per read, no run into the next page
  always @(negedge re_n)
    if (!ce_n)
    begin
      val = cmd == 8'h70 ? {wp_n, rb, rb, 2'b00, edc_valid, edc_err, fail}
        : mark_byte();
      drive = 1'b1;
    end
  // let go on deselect or next write cycle
  always @(posedge ce_n or negedge we_n)
    drive = 1'b0;
endmodule // nesbb_flash_model

// ==== test_nand_edc_status_bad_block.sv ====
// self-checking bench of the flash host controller
`include "nesbb_cfg.svh"
module test_nand_edc_status_bad_block;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // wiring
  // ----------------------------------------
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [31:0] rdata;
  logic cle, ale, ce_n, we_n, re_n, wp_n, io_oe, rb;
  logic [7:0] io_out, io_in, flash_out;
  int miscompares = 0;
  int n_compared = 0;
  logic [31:0] exp_q [$]; // notes of expected reads
  logic [31:0] mask_q [$];
  logic rd_seen = 1'b0;
  logic [31:0] seed = 32'd81;
  logic f, e, v, w, sp;
  logic [1:0] sec;
  logic [11:0] cols [14] = '{12'd0, 12'd255, 12'd256, 12'd511, 12'd512,
    12'd767, 12'd768, 12'd1023, 12'd1024, 12'd1031, 12'd1032, 12'd1047,
    12'd1048, 12'd1055};
  // host drives the shared bus while its enable is up
  assign io_in = io_oe ? io_out : flash_out;
  always #50 sys_clk = ~sys_clk;
  nesbb_host dut (.SYS_CLK(sys_clk), .NRST(nrst), .ADDR(addr),
    .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata), .NAND_CLE(cle),
    .NAND_ALE(ale), .NAND_CE_N(ce_n), .NAND_WE_N(we_n), .NAND_RE_N(re_n),
    .NAND_WP_N(wp_n), .NAND_IO_OE(io_oe), .NAND_IO_OUT(io_out),
    .NAND_IO_IN(io_in), .NAND_RB(rb));
  nesbb_flash_model flash (.cle(cle), .ale(ale), .ce_n(ce_n), .we_n(we_n),
    .re_n(re_n), .wp_n(wp_n), .bus(io_in), .dout(flash_out), .rb(rb));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // one-cycle strobes launched right after an edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge sys_clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge sys_clk);
    rd_s <= 1'b0;
    @(negedge sys_clk);
    d = rdata;
  endtask
  task automatic expect_rd(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] x);
    logic [31:0] d;
    mask_q.push_back(m);
    exp_q.push_back(x);
    rd(a, d);
  endtask
  // bounded poll of the busy flag
  task automatic run_op(input logic [1:0] op);
    logic [31:0] d;
    int n;
    wr(`NESBB_OFF_CMD, {30'h0, op});
    n = 0;
    do
    begin
      rd(`NESBB_OFF_STAT, d);
      n++;
    end
    while (d[8] !== 1'b0 && n < 400);
    if (d[8] !== 1'b0)
    begin
      miscompares++;
      $display("unexpected at %0t: busy never ended", $time);
    end
  endtask
  task automatic mark(input logic [23:0] r, input logic [11:0] c,
    input logic [7:0] b);
    wr(`NESBB_OFF_ROW, {8'h0, r});
    wr(`NESBB_OFF_COL, {20'h0, c});
    run_op(2'h1);
    expect_rd(`NESBB_OFF_STAT, 32'hc3ff, {22'h0, b != 8'hff, 1'b0, b});
  endtask
  task automatic erase(input logic [17:0] blk);
    wr(`NESBB_OFF_ROW, {8'h0, blk, 6'h0});
    run_op(2'h2);
  endtask
  // ----------------------------------------
  // result watcher: oldest note per read
  // ----------------------------------------
  always @(posedge sys_clk)
    rd_seen <= rd_s;
  always @(negedge sys_clk)
    if (rd_seen && exp_q.size() > 0)
      check(rdata & mask_q.pop_front(), exp_q.pop_front());
  // hang guard, well beyond the expected run
  initial
  begin
    #3000000;
    miscompares++;
    $display("unexpected at %0t: watchdog expired", $time);
    final_report();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge sys_clk);
    check({31'h0, ce_n}, 32'h1);
    check({31'h0, wp_n}, 32'h0);
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    wr(8'h14, xs()); // unmapped write ignored
    expect_rd(`NESBB_OFF_COL, 32'hfff, 32'h800);
    expect_rd(8'h14, 32'hffffffff, 32'h0);
    $display("reset test done");
    // every combination of protect, valid, detect-error and fail bits, ready always high
    for (int i = 0; i < 16; i++)
    begin
      {w, v, e, f} = i[3:0];
      wr(`NESBB_OFF_CTRL, {31'h0, w});
      flash.fail = f;
      flash.edc_err = e;
      flash.edc_valid = v;
      run_op(2'h0);
      check({31'h0, wp_n}, {31'h0, w});
      expect_rd(`NESBB_OFF_STAT, 32'h1cff, {19'h0, v, e & v, f, 2'b00, w,
        2'b11, 2'b00, v, e, f});
    end
    {flash.fail, flash.edc_err, flash.edc_valid} = 3'b000;
    $display("status test done");
    foreach (cols[k])
    begin
      wr(`NESBB_OFF_COL, {20'h0, cols[k]});
      sp = cols[k] >= 12'd1024;
      sec = sp ? 2'((cols[k] - 12'd1024) >> 3) : 2'(cols[k] >> 8);
      expect_rd(`NESBB_OFF_STAT, 32'h70000, {13'h0, sp, sec, 16'h0});
    end
    $display("sector test done");
    // erase before any scan is refused
    wr(`NESBB_OFF_CTRL, 32'h1);
    erase(18'd5);
    expect_rd(`NESBB_OFF_STAT, 32'h4000, 32'h4000);
    check(flash.erases, 32'h0);
    wr(`NESBB_OFF_CTRL, 32'h5);
    mark(24'h0, 12'h800, 8'hff);
    mark({18'd5, 6'd0}, 12'h800, 8'h00);
    mark({18'd5, 6'd1}, 12'h800, 8'hff);
    mark({18'(8 + xs() % 1000), 6'd63}, 12'h800, 8'hff);
    mark({18'(8 + xs() % 1000), 6'd61}, 12'h800, 8'hff);
    mark(24'(xs() % 64), 12'(xs() % 2048), 8'hff);
    mark(24'h0, 12'h83f, 8'hff);
    wr(`NESBB_OFF_COL, 32'h840);
    run_op(2'h1);
    expect_rd(`NESBB_OFF_STAT, 32'hc000, 32'hc000);
    $display("marker test done");
    wr(`NESBB_OFF_CTRL, 32'h7);
    erase(18'd7);
    expect_rd(`NESBB_OFF_STAT, 32'h24ff, 32'h24e1);
    flash.busy_ns = 20000;
    erase(18'd5);
    expect_rd(`NESBB_OFF_STAT, 32'h2401, 32'h2000);
    check(flash.erases, 32'h2);
    mark({18'd5, 6'd0}, 12'h800, 8'hff);
    wr(`NESBB_OFF_CTRL, 32'h7);
    expect_rd(`NESBB_OFF_STAT, 32'h6000, 32'h0);
    wr(`NESBB_OFF_CTRL, 32'h2);
    erase(18'd9);
    check(flash.erases, 32'h2);
    check({31'h0, wp_n}, 32'h0);
    $display("erase test done");
    final_report();
  end
endmodule // test_nand_edc_status_bad_block
